// ===== hw/mrb_defines.vh
/*
 mrb_defines.vh: field positions, codes and counts for the base burst/latency
 mode register logic. assumes inclusion by bare name from the design files.
*/
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH

// register width and fields
`define MRB_REG_W        18
`define MRB_BL_LO        0
`define MRB_BL_HI        1
`define MRB_BT_BIT       3
`define MRB_CL_LO        4
`define MRB_CL_HI        6
`define MRB_DLLRST_BIT   8
`define MRB_WR_LO        9
`define MRB_WR_HI        11
`define MRB_PPD_BIT      12
`define MRB_RSVD_MASK    18'h2_6080
`define MRB_RESET_VAL    18'h0_0000

// burst length codes
`define MRB_BL_FIX8      2'h0
`define MRB_BL_OTF       2'h1
`define MRB_BL_FIX4      2'h2
`define MRB_BL_RSVD      2'h3

// burst beat counts
`define MRB_BEATS8       4'h8
`define MRB_BEATS4       4'h4

// latency figures in cycles
`define MRB_DLLK_CYC     10'h200
`define MRB_MOD_CYC      5'h0c
`define MRB_CL_MAX       4'he

`endif

// ===== hw/mrb_mode_reg.v
/*
 mrb_mode_reg.v: base burst/latency mode register with burst sequencing,
 read latency timing, write recovery and dll control outputs.
 assumes synchronous command inputs on ref_clk from a memory controller.
*/
// How it works
// - on-the-fly code: a12 low selects chop four, high selects eight beats
// - bursts wrap within an aligned block of four or eight columns
// - one burst length setting serves reads and writes alike
// - bit 3 picks sequential or interleaved ordering
// - eight-beat reads: sequential nibble wrap, interleaved start xor beat
// - chopped reads: four beats then drivers off four slots
// - chopped writes: column bit 2 picks nibble, ascending, last four ignored
// - eight-beat writes ignore low column bits, ascending order
// - internal operation starts at same time for chop and eight
// - writing bit 8 starts dll reset, bit then self-clears
// - write recovery from bits 11:9: 5,6,7,8,10,12 cycles
// - bit 12 low stops dll in precharge power-down
// - bit 12 high keeps dll running in precharge power-down
// - read latency from bits 6:4, five to eleven cycles
// - only whole-cycle read latencies exist
// - read at edge n gives first data at edge n plus latency
// - contents held until next load or reset, bit 8 excepted
// - new settings take effect on load; mode_ready_ff stays low for the mode-update delay
`timescale 1ns/1ps
`default_nettype none
`include "mrb_defines.vh"

module mrb_mode_reg #(
   parameter MOD_CYC  = `MRB_MOD_CYC,
   parameter DLLK_CYC = `MRB_DLLK_CYC
) (
   // clock and reset
   input  wire                     ref_clk,
   input  wire                     resetn,
   // mode register load
   input  wire                     mode_load,
   input  wire [`MRB_REG_W-1:0]    mode_data,
   // column commands and power-down state
   input  wire                     rd_cmd,
   input  wire                     wr_cmd,
   input  wire [2:0]               col_addr,
   input  wire                     a12,
   input  wire                     ppd_active,
   // read data timing
   output reg                      rd_beat_valid_ff,
   output reg  [2:0]               rd_col_ff,
   output reg                      rd_drive_ff,
   output reg                      rd_hiz_oe_n_ff,
   // write data timing
   output reg                      wr_beat_valid_ff,
   output reg  [2:0]               wr_col_ff,
   output reg                      wr_store_ff,
   // decoded settings and ready status
   output wire [3:0]               burst_beats,
   output wire                     interleave,
   output wire [3:0]               read_lat,
   output wire [3:0]               write_rec,
   output wire                     cfg_reserved,
   output reg                      mode_ready_ff,
   // dll control and register value
   output reg                      dll_reset_ff,
   output reg                      dll_locked_ff,
   output wire                     dll_run,
   output wire                     ppd_slow_exit,
   output wire [`MRB_REG_W-1:0]    mode_value
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DATA = 2'h2;

   reg  [`MRB_REG_W-1:0] mode_ff;
   reg  [4:0]            mod_cnt_ff;
   reg  [9:0]            dllk_cnt_ff;
   reg  [1:0]            rd_st_ff;
   reg  [3:0]            rd_wait_ff;
   reg  [2:0]            rd_beat_ff;
   reg  [2:0]            rd_start_ff;
   reg                   rd_chop_ff;
   reg                   rd_il_ff;
   reg                   wr_act_ff;
   reg  [2:0]            wr_beat_ff;
   reg  [2:0]            wr_start_ff;
   reg                   wr_chop_ff;
   wire [2:0]            rd_col_nxt;
   wire [2:0]            wr_col_nxt;
   wire                  cmd_chop;
   wire [1:0]            bl_code;

   // write recovery decode, zero when reserved
   function [3:0] wr_decode;
      input [2:0] code;
      begin
         case (code)
            3'h1:    wr_decode = 4'h5;
            3'h2:    wr_decode = 4'h6;
            3'h3:    wr_decode = 4'h7;
            3'h4:    wr_decode = 4'h8;
            3'h5:    wr_decode = 4'ha;
            3'h6:    wr_decode = 4'hc;
            default: wr_decode = 4'h0;
         endcase
      end
   endfunction

   function [3:0] cl_decode;
      input [2:0] code;
      begin
         case (code)
            3'h0:    cl_decode = 4'h0;
            default: cl_decode = {1'b0, code} + 4'h4;
         endcase
      end
   endfunction

   assign bl_code = mode_ff[`MRB_BL_HI:`MRB_BL_LO];

   assign cmd_chop = (bl_code == `MRB_BL_FIX4) ||
                     ((bl_code == `MRB_BL_OTF) && !a12);
   assign burst_beats = (bl_code == `MRB_BL_FIX4) ? `MRB_BEATS4 : `MRB_BEATS8;

   assign interleave = mode_ff[`MRB_BT_BIT];

   assign read_lat = cl_decode(mode_ff[`MRB_CL_HI:`MRB_CL_LO]);

   assign write_rec = wr_decode(mode_ff[`MRB_WR_HI:`MRB_WR_LO]);

   assign cfg_reserved = (bl_code == `MRB_BL_RSVD) || (read_lat == 4'h0) ||
                         (write_rec == 4'h0);

   // dll stops in power-down when bit low
   // dll runs in power-down when bit high
   assign dll_run       = !ppd_active || mode_ff[`MRB_PPD_BIT];
   assign ppd_slow_exit = !mode_ff[`MRB_PPD_BIT];

   assign mode_value = mode_ff;

   // register held until load or reset
   always @(posedge ref_clk) begin
      if (!resetn) begin
         mode_ff      <= `MRB_RESET_VAL;
         dll_reset_ff <= 1'b0;
      end else if (mode_load) begin
         mode_ff      <= mode_data & ~`MRB_RSVD_MASK & ~(18'h0_0001 << `MRB_DLLRST_BIT);
         dll_reset_ff <= mode_data[`MRB_DLLRST_BIT];
      end else begin
         dll_reset_ff <= 1'b0;
      end
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         mod_cnt_ff    <= 5'h00;
         mode_ready_ff <= 1'b1;
      end else if (mode_load) begin
         mod_cnt_ff    <= MOD_CYC[4:0];
         mode_ready_ff <= 1'b0;
      end else if (mod_cnt_ff > 5'h01) begin
         mod_cnt_ff <= mod_cnt_ff - 5'h01;
      end else begin
         mod_cnt_ff    <= 5'h00;
         mode_ready_ff <= 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         dllk_cnt_ff   <= 10'h000;
         dll_locked_ff <= 1'b0;
      end else if (dll_reset_ff) begin
         dllk_cnt_ff   <= DLLK_CYC[9:0];
         dll_locked_ff <= 1'b0;
      end else if (dllk_cnt_ff > 10'h001) begin
         dllk_cnt_ff <= dllk_cnt_ff - 10'h001;
      end else begin
         dllk_cnt_ff   <= 10'h000;
         dll_locked_ff <= 1'b1;
      end
   end

   mrb_order u_rd_order (
      .start_col  (rd_start_ff),
      .interleave (rd_il_ff),
      .chop       (rd_chop_ff),
      .is_write   (1'b0),
      .beat       (rd_beat_ff),
      .col        (rd_col_nxt)
   );

   mrb_order u_wr_order (
      .start_col  (wr_start_ff),
      .interleave (1'b0),
      .chop       (wr_chop_ff),
      .is_write   (1'b1),
      .beat       (wr_beat_ff),
      .col        (wr_col_nxt)
   );

   // first data at read edge plus latency
   // same start for chop and eight
   always @(posedge ref_clk) begin
      if (!resetn) begin
         rd_st_ff    <= ST_IDLE;
         rd_wait_ff  <= 4'h0;
         rd_beat_ff  <= 3'h0;
         rd_start_ff <= 3'h0;
         rd_chop_ff  <= 1'b0;
         rd_il_ff    <= 1'b0;
      end else begin
         case (rd_st_ff)
            ST_IDLE: begin
               if (rd_cmd && read_lat != 4'h0) begin
                  rd_start_ff <= col_addr;
                  rd_chop_ff  <= cmd_chop;
                  rd_il_ff    <= interleave;
                  rd_beat_ff  <= 3'h0;
                  rd_wait_ff  <= read_lat - 4'h1;
                  rd_st_ff    <= (read_lat == 4'h1) ? ST_DATA : ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (rd_wait_ff == 4'h1)
                  rd_st_ff <= ST_DATA;
               rd_wait_ff <= rd_wait_ff - 4'h1;
            end
            ST_DATA: begin
               rd_beat_ff <= rd_beat_ff + 3'h1;
               if (rd_beat_ff == 3'h7)
                  rd_st_ff <= ST_IDLE;
            end
            default: rd_st_ff <= ST_IDLE;
         endcase
      end
   end

   // chop reads drive four, then off four
   always @(posedge ref_clk) begin
      if (!resetn) begin
         rd_beat_valid_ff <= 1'b0;
         rd_col_ff        <= 3'h0;
         rd_drive_ff      <= 1'b0;
         rd_hiz_oe_n_ff   <= 1'b1;
      end else if (rd_st_ff == ST_DATA) begin
         rd_beat_valid_ff <= !(rd_chop_ff && rd_beat_ff[2]);
         rd_col_ff        <= rd_col_nxt;
         rd_drive_ff      <= !(rd_chop_ff && rd_beat_ff[2]);
         rd_hiz_oe_n_ff   <= rd_chop_ff && rd_beat_ff[2];
      end else begin
         rd_beat_valid_ff <= 1'b0;
         rd_drive_ff      <= 1'b0;
         rd_hiz_oe_n_ff   <= 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         wr_act_ff        <= 1'b0;
         wr_beat_ff       <= 3'h0;
         wr_start_ff      <= 3'h0;
         wr_chop_ff       <= 1'b0;
         wr_beat_valid_ff <= 1'b0;
         wr_col_ff        <= 3'h0;
         wr_store_ff      <= 1'b0;
      end else begin
         if (!wr_act_ff && wr_cmd) begin
            wr_act_ff   <= 1'b1;
            wr_beat_ff  <= 3'h0;
            wr_start_ff <= col_addr;
            wr_chop_ff  <= cmd_chop;
         end else if (wr_act_ff) begin
            wr_beat_ff <= wr_beat_ff + 3'h1;
            if (wr_beat_ff == 3'h7)
               wr_act_ff <= 1'b0;
         end
         wr_beat_valid_ff <= wr_act_ff;
         wr_col_ff        <= wr_col_nxt;
         wr_store_ff      <= wr_act_ff && !(wr_chop_ff && wr_beat_ff[2]);
      end
   end

endmodule

`default_nettype wire

// ===== hw/mrb_order.v
/*
 mrb_order.v: column order of one burst beat.
 assumes beat index 0..7 and a 3-bit starting column.
*/
`timescale 1ns/1ps
`default_nettype none

module mrb_order (
   // burst setup
   input  wire [2:0] start_col,
   input  wire       interleave,
   input  wire       chop,
   input  wire       is_write,
   // beat
   input  wire [2:0] beat,
   output reg  [2:0] col
);

   always @* begin
      if (is_write) begin
         if (chop)
            col = {start_col[2], beat[1:0]};
         else
            col = beat;
      end else if (interleave) begin
         col = start_col ^ beat;
      end else begin
         col = {start_col[2] ^ beat[2], start_col[1:0] + beat[1:0]};
      end
   end

endmodule

`default_nettype wire

// ===== verification/mrb_ctrl_model.sv
/*
 mrb_ctrl_model.sv: controller model issuing loads, reads and writes.
 assumes the device samples on the rising edge; drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mrb_ctrl_model (
   // clock and lock status
   input wire logic        ref_clk,
   input wire logic        dll_locked_ff,
   // command outputs
   output var logic        mode_load,
   output var logic [17:0] mode_data,
   output var logic        rd_cmd,
   output var logic        wr_cmd,
   output var logic [2:0]  col_addr,
   output var logic        a12
);
   initial begin
      mode_load = 1'b0;
      mode_data = 18'h0_0000;
      rd_cmd    = 1'b0;
      wr_cmd    = 1'b0;
      col_addr  = 3'h0;
      a12       = 1'b0;
   end
   // whole word, reserved zero unless raw
   task automatic ld(input logic [17:0] d, input logic raw);
      @(negedge ref_clk);
      mode_load = 1'b1;
      mode_data = raw ? d : d & 18'h1_9f7f;
      @(negedge ref_clk);
      mode_load = 1'b0;
      mode_data = ~mode_data;
   endtask
   task automatic cmd(input logic wr, input logic [2:0] c, input logic a);
      int n;
      n = 0;
      while (!wr && dll_locked_ff !== 1'b1 && n < 999) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      rd_cmd   = !wr;
      wr_cmd   = wr;
      col_addr = c;
      a12      = a;
      @(negedge ref_clk);
      rd_cmd   = 1'b0;
      wr_cmd   = 1'b0;
      col_addr = ~c;
      a12      = !a;
   endtask
endmodule
`default_nettype wire

// ===== verification/mrb_mode_reg_monitor.sv
/*
 mrb_mode_reg_monitor.sv: port assertions for the mode register block.
 assumes bind onto mrb_mode_reg, one clock, synchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mrb_mode_reg_monitor (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // commands
   input wire logic        mode_load,
   input wire logic [17:0] mode_data,
   input wire logic        wr_cmd,
   // observed outputs
   input wire logic        rd_drive_ff,
   input wire logic        rd_hiz_oe_n_ff,
   input wire logic        wr_beat_valid_ff,
   input wire logic        wr_store_ff,
   input wire logic        mode_ready_ff,
   input wire logic        dll_reset_ff,
   input wire logic [17:0] mode_value
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   AST_DLL_PULSE: assert property (mode_load && mode_data[8] |=> dll_reset_ff ##1 !dll_reset_ff)
      else $error("dll reset pulse wrong");
   AST_LOAD_VAL: assert property (mode_load |=> mode_value == ($past(mode_data) & 18'h1_9e7f))
      else $error("loaded value wrong");
   AST_HOLD: assert property (!mode_load |=> $stable(mode_value))
      else $error("mode value changed without load");
   AST_READY: assert property (mode_load |=> !mode_ready_ff)
      else $error("ready not dropped after load");
   AST_HIZ: assert property (rd_hiz_oe_n_ff != rd_drive_ff)
      else $error("hiz enable disagrees with drive");
   AST_RD_DRIVE4: assert property ($rose(rd_drive_ff) |-> rd_drive_ff [*4])
      else $error("read drove fewer than four beats");
   AST_WR_BEATS: assert property (wr_cmd && !wr_beat_valid_ff && !$past(wr_cmd)
      |=> !wr_beat_valid_ff ##1 wr_beat_valid_ff [*8] ##1 !wr_beat_valid_ff)
      else $error("write beat slots wrong");
   AST_WR_STORE: assert property ($rose(wr_beat_valid_ff) |-> wr_store_ff [*4])
      else $error("first write beats not stored");
endmodule
bind mrb_mode_reg mrb_mode_reg_monitor i_mrb_mode_reg_monitor (.ref_clk, .resetn, .mode_load,
   .mode_data, .wr_cmd, .rd_drive_ff, .rd_hiz_oe_n_ff, .wr_beat_valid_ff, .wr_store_ff,
   .mode_ready_ff, .dll_reset_ff, .mode_value);
`default_nettype wire

// ===== verification/test_ddr3_mode_register0_burst_logic.sv
/*
 test_ddr3_mode_register0_burst_logic.sv: self-checking bench of the mode register.
 assumes the controller model issues commands; the bench judges outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ddr3_mode_register0_burst_logic;
   localparam int MOD  = 4;
   localparam int DLLK = 8;
   logic        ref_clk, resetn, ppd_active, mode_load, rd_cmd, wr_cmd, a12;
   logic [17:0] mode_data, mode_value;
   logic [2:0]  col_addr, rd_col_ff, wr_col_ff;
   logic [3:0]  burst_beats, read_lat, write_rec;
   logic        rd_beat_valid_ff, rd_drive_ff, rd_hiz_oe_n_ff, wr_beat_valid_ff, wr_store_ff;
   logic        interleave, cfg_reserved, mode_ready_ff, dll_reset_ff, dll_locked_ff;
   logic        dll_run, ppd_slow_exit;
   int          mismatches, tests_run;
   mrb_mode_reg #(.MOD_CYC(MOD), .DLLK_CYC(DLLK)) i_mrb_mode_reg (
      .ref_clk, .resetn, .mode_load, .mode_data, .rd_cmd, .wr_cmd, .col_addr, .a12,
      .ppd_active, .rd_beat_valid_ff, .rd_col_ff, .rd_drive_ff, .rd_hiz_oe_n_ff,
      .wr_beat_valid_ff, .wr_col_ff, .wr_store_ff, .burst_beats, .interleave, .read_lat,
      .write_rec, .cfg_reserved, .mode_ready_ff, .dll_reset_ff, .dll_locked_ff, .dll_run,
      .ppd_slow_exit, .mode_value);
   mrb_ctrl_model i_mrb_ctrl_model (.ref_clk, .dll_locked_ff, .mode_load, .mode_data,
      .rd_cmd, .wr_cmd, .col_addr, .a12);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_decode;
      logic [17:0] d;
      logic [3:0]  wrt [8];
      wrt = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h0};
      ppd_active = 1'b1;
      for (int k = 0; k < 8; k++) begin
         d = {5'h00, k[1], k[2:0], 2'h0, k[2:0], k[0], 1'b0, k[1:0]};
         i_mrb_ctrl_model.ld(d, 1'b0);
         chk(mode_value, d);
         chk(read_lat, k == 0 ? 0 : k + 4);
         chk(write_rec, wrt[k]);
         chk(burst_beats, k[1:0] == 2 ? 4 : 8);
         chk(interleave, k[0]);
         chk(cfg_reserved, k == 0 || k == 7 || k[1:0] == 3);
         chk(ppd_slow_exit, !k[1]);
         chk(dll_run, k[1]);
      end
      ppd_active = 1'b0;
      @(negedge ref_clk);
      chk(dll_run, 1);
   endtask
   task automatic t_dll;
      int n;
      i_mrb_ctrl_model.ld(18'h3_ffff, 1'b0);
      chk(mode_value, 18'h1_9e7f);
      chk(dll_reset_ff, 1);
      chk(mode_ready_ff, 0);
      @(negedge ref_clk);
      chk(dll_reset_ff, 0);
      chk(dll_locked_ff, 0);
      repeat (MOD - 2) @(negedge ref_clk);
      chk(mode_ready_ff, 0);
      @(negedge ref_clk);
      chk(mode_ready_ff, 1);
      n = 0;
      while (dll_locked_ff !== 1'b1 && n < DLLK + 4) begin
         @(negedge ref_clk);
         n++;
      end
      chk(dll_locked_ff, 1);
   endtask
   task automatic t_rw;
      logic [1:0] bl;
      logic [2:0] e;
      logic       ch, a;
      int         lat;
      for (int m = 0; m < 4; m++) begin
         for (int bt = 0; bt < 2; bt++) begin
            bl  = m == 3 ? 2'h1 : m[1:0];
            a   = m == 3;
            ch  = m == 1 || m == 2;
            lat = m * 2 + 5;
            // whole-cycle latency code, load only between bursts
            i_mrb_ctrl_model.ld({6'h00, 3'h1, 2'h0, 3'(m * 2 + 1), bt[0], 1'b0, bl}, 1'b0);
            repeat (MOD) @(negedge ref_clk);
            for (int c = 0; c < 8; c++) begin
               i_mrb_ctrl_model.cmd(1'b0, c[2:0], a);
               repeat (lat - 1) @(negedge ref_clk);
               chk(rd_drive_ff, 0);
               for (int s = 0; s < 8; s++) begin
                  @(negedge ref_clk);
                  e = bt[0] ? c[2:0] ^ s[2:0] : {c[2] ^ s[2], c[1:0] + s[1:0]};
                  chk(rd_beat_valid_ff, !ch || s < 4);
                  chk(rd_hiz_oe_n_ff, ch && s > 3);
                  if (!ch || s < 4)
                     chk(rd_col_ff, e);
               end
               i_mrb_ctrl_model.cmd(1'b1, c[2:0], a);
               chk(wr_beat_valid_ff, 0);
               for (int s = 0; s < 8; s++) begin
                  @(negedge ref_clk);
                  chk(wr_beat_valid_ff, 1);
                  chk(wr_store_ff, !ch || s < 4);
                  if (!ch || s < 4)
                     chk(wr_col_ff, ch ? {c[2], s[1:0]} : s[2:0]);
               end
            end
         end
      end
   endtask
   initial begin
      mismatches = 0;
      tests_run  = 0;
      resetn     = 1'b0;
      ppd_active = 1'b0;
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      chk(mode_value, 0);
      chk(rd_hiz_oe_n_ff, 1);
      t_decode;
      t_dll;
      t_rw;
      test_done;
   end
   // watchdog, several times the expected run
   initial begin
      #250000;
      mismatches++;
      test_done;
   end
endmodule
`default_nettype wire
